// [sim/tdsc_otp_model.sv]
`timescale 1ns/1ps
// far side: otp loader and processor debug state
module tdsc_otp_model (
	// clock
	input  wire logic        core_clk,
	// towards the block
	output logic             otp_word_valid,
	output logic [31:0]      otp_word,
	output logic             cpu_debug_mode
);
	// idle state at time zero
	initial begin
		otp_word_valid = 1'b0;
		otp_word       = 32'h0000_0000;
		cpu_debug_mode = 1'b0;
	end
	// one-cycle load pulse; word turns to garbage once the pulse ends
	task automatic load(input logic [31:0] w);
		@(negedge core_clk);
		otp_word_valid = 1'b1;
		otp_word       = w;
		@(negedge core_clk);
		otp_word_valid = 1'b0;
		otp_word       = ~w;
	endtask
	// processor enters or leaves debug mode
	task automatic set_mode(input logic m);
		@(negedge core_clk);
		cpu_debug_mode = m;
		@(negedge core_clk);
	endtask
endmodule // tdsc_otp_model

// [sim/tile_debug_security_config_regs_tb.sv]
`timescale 1ns/1ps
module tile_debug_security_config_regs_tb;
	localparam tdsc_pkg::tdsc_src_e SYS = tdsc_pkg::SRC_SYSTEM_SWITCH;
	localparam tdsc_pkg::tdsc_src_e MB  = tdsc_pkg::SRC_MAILBOX_PATH;
	localparam tdsc_pkg::tdsc_src_e JT  = tdsc_pkg::SRC_JTAG;
	localparam tdsc_pkg::tdsc_src_e OTH = tdsc_pkg::SRC_OTHER;
	logic                core_clk, rst_n, req_valid, req_write, tile_div_enable;
	tdsc_pkg::tdsc_src_e req_src;
	logic [7:0]          req_addr;
	logic [31:0]         req_wdata, rsp_rdata, otp_word;
	logic                rsp_valid, rsp_refused, otp_word_valid, cpu_debug_mode, debug_irq;
	logic                tile_clk_off, tile_div_active, global_debug_block, boot_from_otp;
	logic                jtag_pll_boot_deny, jtag_tap_deny;
	logic [15:0]         tile_div_ratio;
	logic [3:0]          otp_sector_lock;
	int                  miscompares, check_count;
	// security controls gathered for one compare
	wire [7:0] sec_out = {global_debug_block, otp_sector_lock, boot_from_otp, jtag_pll_boot_deny, jtag_tap_deny};

	tdsc_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_refused(rsp_refused), .rsp_rdata(rsp_rdata), .otp_word_valid(otp_word_valid),
		.otp_word(otp_word), .cpu_debug_mode(cpu_debug_mode), .tile_div_enable(tile_div_enable),
		.debug_irq(debug_irq), .tile_clk_off(tile_clk_off), .tile_div_ratio(tile_div_ratio),
		.tile_div_active(tile_div_active), .global_debug_block(global_debug_block),
		.otp_sector_lock(otp_sector_lock), .boot_from_otp(boot_from_otp),
		.jtag_pll_boot_deny(jtag_pll_boot_deny), .jtag_tap_deny(jtag_tap_deny));
	tdsc_otp_model i_otp (.core_clk(core_clk), .otp_word_valid(otp_word_valid), .otp_word(otp_word),
		.cpu_debug_mode(cpu_debug_mode));

	////////////////////////////////////////////////////////////////////////////////
	// 25 ns clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one request; the answer is looked at in the cycle after it is taken
	task automatic acc(input tdsc_pkg::tdsc_src_e s, input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] exp_d, input logic exp_r);
		@(negedge core_clk);
		req_valid = 1'b1;
		req_write = w;
		req_src   = s;
		req_addr  = a;
		req_wdata = d;
		@(negedge core_clk);
		req_valid = 1'b0;
		req_wdata = ~d;
		chk({31'h0, rsp_valid}, 32'h1);
		chk({31'h0, rsp_refused}, {31'h0, exp_r});
		chk(rsp_rdata, exp_d);
	endtask
	// counts, verdict, stop
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		miscompares = 0;
		check_count = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_src = SYS;
		req_addr = 8'h00;
		req_wdata = 32'h0000_0000;
		tile_div_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		// reset values, unmapped place reads zero
		for (int a = 4; a < 9; a++) begin
			acc(SYS, 1'b0, a[7:0], 32'h0, 32'h0, 1'b0);
		end
		acc(SYS, 1'b1, 8'h08, 32'hffff_ffff, 32'h0, 1'b0);
		acc(SYS, 1'b0, 8'h08, 32'h0, 32'h0, 1'b0);
		$display("test reset done");
		// security copy, masking and write lock
		i_otp.load(32'h7fff_ffff);
		acc(MB, 1'b0, 8'h07, 32'h0, 32'h0000_5fb1, 1'b0);
		chk({24'h0, sec_out}, 32'h0000_00ff);
		i_otp.load(32'h0000_1021);
		chk({28'h0, otp_sector_lock}, 32'h0000_000f);
		chk({31'h0, boot_from_otp}, 32'h1);
		chk({31'h0, jtag_tap_deny}, 32'h1);
		chk({24'h0, sec_out}, 32'h0000_007d);
		i_otp.load(32'h0000_0310);
		chk({24'h0, sec_out}, 32'h0000_001a);
		chk({31'h0, jtag_pll_boot_deny}, 32'h1);
		acc(MB, 1'b1, 8'h07, 32'hffff_ffff, 32'h0, 1'b0);
		acc(MB, 1'b0, 8'h07, 32'h0, 32'h8000_5fb1, 1'b0);
		acc(JT, 1'b1, 8'h07, 32'h0, 32'h0, 1'b1);
		acc(JT, 1'b0, 8'h07, 32'h0, 32'h8000_5fb1, 1'b0);
		$display("test security done");
		// divider and clock gate
		acc(JT, 1'b1, 8'h06, 32'hffff_ffff, 32'h0, 1'b0);
		acc(JT, 1'b0, 8'h06, 32'h0, 32'h8000_ffff, 1'b0);
		chk({15'h0, tile_clk_off, tile_div_ratio}, 32'h0001_ffff);
		chk({31'h0, tile_div_active}, 32'h0);
		tile_div_enable = 1'b1;
		@(negedge core_clk);
		chk({31'h0, tile_div_active}, 32'h1);
		$display("test divider done");
		// debug interrupt and debug mode flag
		acc(SYS, 1'b1, 8'h05, 32'hffff_ffff, 32'h0, 1'b0);
		chk({31'h0, debug_irq}, 32'h1);
		i_otp.set_mode(1'b1);
		acc(SYS, 1'b0, 8'h05, 32'h0, 32'h3, 1'b0);
		i_otp.set_mode(1'b0);
		acc(SYS, 1'b1, 8'h05, 32'h0, 32'h0, 1'b0);
		chk({31'h0, debug_irq}, 32'h0);
		acc(SYS, 1'b0, 8'h05, 32'h0, 32'h0, 1'b0);
		$display("test interrupt done");
		// write protection by source
		acc(MB, 1'b1, 8'h04, 32'h0000_0001, 32'h0, 1'b0);
		acc(SYS, 1'b1, 8'h06, 32'h5, 32'h0, 1'b1);
		acc(JT, 1'b1, 8'h06, 32'h5, 32'h0, 1'b0);
		acc(SYS, 1'b0, 8'h06, 32'h0, 32'h5, 1'b0);
		acc(JT, 1'b1, 8'h04, 32'hffff_ffff, 32'h0, 1'b0);
		acc(JT, 1'b0, 8'h04, 32'h0, 32'h8000_0001, 1'b0);
		acc(MB, 1'b1, 8'h05, 32'h1, 32'h0, 1'b1);
		acc(JT, 1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
		acc(OTH, 1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
		acc(MB, 1'b0, 8'h06, 32'h0, 32'h5, 1'b0);
		$display("test protection done");
		// mid-run reset clears the lock and the security copy
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		chk({24'h0, sec_out}, 32'h0);
		acc(SYS, 1'b0, 8'h04, 32'h0, 32'h0, 1'b0);
		acc(SYS, 1'b1, 8'h06, 32'h8000_0004, 32'h0, 1'b0);
		chk({15'h0, tile_clk_off, tile_div_ratio}, 32'h0001_0004);
		$display("test reset again done");
		end_sim();
	end
endmodule // tile_debug_security_config_regs_tb

// [src/tdsc_map.svh]
`ifndef TDSC_MAP_SVH
`define TDSC_MAP_SVH
// register numbers on the configuration port
`define TDSC_OFS_PERM      8'h04
`define TDSC_OFS_DBGIRQ    8'h05
`define TDSC_OFS_CLKDIV    8'h06
`define TDSC_OFS_SECURITY  8'h07
// debug write permission fields
`define TDSC_PERM_ALL_BIT  31
`define TDSC_PERM_SYS_BIT  0
`define TDSC_PERM_MASK     32'h8000_0001
// debug interrupt fields
`define TDSC_IRQ_REQ_BIT   0
`define TDSC_IRQ_MODE_BIT  1
// clock divider fields
`define TDSC_DIV_OFF_BIT   31
`define TDSC_DIV_MASK      32'h8000_ffff
// security word fields
`define TDSC_SEC_WLOCK_BIT 31
`define TDSC_SEC_GDBG_BIT  14
`define TDSC_SEC_ALLOTP    12
`define TDSC_SEC_SECT_HI   11
`define TDSC_SEC_SECT_LO   8
`define TDSC_SEC_BOOT_BIT  5
`define TDSC_SEC_JPLL_BIT  4
`define TDSC_SEC_JTAP_BIT  0
`define TDSC_SEC_MASK      32'h8000_5fb1
// reset value of every writable register
`define TDSC_RESET_WORD    32'h0000_0000
`endif

// [src/tdsc_pkg.sv]
package tdsc_pkg;
	// origin of a configuration request
	typedef enum logic [1:0] {
		SRC_SYSTEM_SWITCH,
		SRC_MAILBOX_PATH,
		SRC_JTAG,
		SRC_OTHER
	} tdsc_src_e;

	// complete register state of the block
	typedef struct packed {
		logic [31:0] perm;        // debug write permission
		logic        irq_req;     // debug interrupt request
		logic        dbg_mode;    // sampled processor debug mode
		logic        clk_off;     // tile clock gate off
		logic [15:0] div_ratio;   // divider ratio
		logic        div_active;  // divider running
		logic [31:0] sec;         // security word copy
		logic [3:0]  otp_lock;    // per-sector lock
		logic        rsp_valid;   // answer strobe
		logic        rsp_refused; // write refused
		logic [31:0] rsp_rdata;   // read data
	} tdsc_state_s;
endpackage

// [src/tdsc_regs.sv]
`timescale 1ns/1ps
`include "tdsc_map.svh"
// Behaviour
// - perm bit 31 blocks all debug writes
// - perm bit 0 blocks system switch writes
// - irq bit 0 raises debug interrupt
// - irq bit 1 reads processor debug mode
// - divider bit 31 gates tile clock off
// - divider bits 15:0 give clock ratio
// - divider works only when control enables
// - security register shows loaded OTP word or a permitted write, masked by TDSC_SEC_MASK
// - security bit 31 refuses security register writes
// - security bit 14 blocks global debug
// - security bit 12 locks all sectors
// - security bits 11:8 lock single sectors
// - security bit 5 forces OTP boot
// - security bit 4 denies JTAG PLL/boot
// - security bit 0 denies JTAG TAP
module tdsc_regs (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// configuration request
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire tdsc_pkg::tdsc_src_e  req_src,
	input  wire logic [7:0]           req_addr,
	input  wire logic [31:0]          req_wdata,
	// configuration answer
	output logic                      rsp_valid,
	output logic                      rsp_refused,
	output logic [31:0]               rsp_rdata,
	// security word from OTP
	input  wire logic                 otp_word_valid,
	input  wire logic [31:0]          otp_word,
	// processor and tile control
	input  wire logic                 cpu_debug_mode,
	input  wire logic                 tile_div_enable,
	output logic                      debug_irq,
	output logic                      tile_clk_off,
	output logic [15:0]               tile_div_ratio,
	output logic                      tile_div_active,
	// security controls
	output logic                      global_debug_block,
	output logic [3:0]                otp_sector_lock,
	output logic                      boot_from_otp,
	output logic                      jtag_pll_boot_deny,
	output logic                      jtag_tap_deny
);
	////////////////////////////////////////////////////////////////////////
	tdsc_pkg::tdsc_state_s st;       // registered state
	tdsc_pkg::tdsc_state_s next_st;  // next state
	logic                  dbg_wr_ok;  // debug register write allowed
	logic                  wr;         // write request this cycle
	logic [31:0]           rd_word;    // decoded read value

	////////////////////////////////////////////////////////////////////////
	// write protection of the debug registers
	always_comb begin
		dbg_wr_ok = 1'b1;
		if (st.perm[`TDSC_PERM_ALL_BIT]) begin
			dbg_wr_ok = 1'b0;
		end else if (st.perm[`TDSC_PERM_SYS_BIT] && req_src == tdsc_pkg::SRC_SYSTEM_SWITCH) begin
			dbg_wr_ok = 1'b0;
		end
	end

	// read decode, reserved bits zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (req_addr == `TDSC_OFS_PERM) begin
			rd_word = st.perm;
		end else if (req_addr == `TDSC_OFS_DBGIRQ) begin
			rd_word[`TDSC_IRQ_REQ_BIT]  = st.irq_req;
			rd_word[`TDSC_IRQ_MODE_BIT] = st.dbg_mode;
		end else if (req_addr == `TDSC_OFS_CLKDIV) begin
			rd_word[`TDSC_DIV_OFF_BIT] = st.clk_off;
			rd_word[15:0]              = st.div_ratio;
		end else if (req_addr == `TDSC_OFS_SECURITY) begin
			rd_word = st.sec;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state of every register
	always_comb begin
		next_st             = st;
		wr                  = req_valid && req_write;
		next_st.rsp_valid   = req_valid;
		next_st.rsp_refused = 1'b0;
		next_st.rsp_rdata   = (req_valid && !req_write) ? rd_word : 32'h0000_0000;
		next_st.dbg_mode    = cpu_debug_mode;
		next_st.div_active  = tile_div_enable;
		// debug registers
		if (wr && (req_addr == `TDSC_OFS_PERM || req_addr == `TDSC_OFS_DBGIRQ
			|| req_addr == `TDSC_OFS_CLKDIV)) begin
			if (!dbg_wr_ok) begin
				next_st.rsp_refused = 1'b1;
			end else if (req_addr == `TDSC_OFS_PERM) begin
				next_st.perm = req_wdata & `TDSC_PERM_MASK;
			end else if (req_addr == `TDSC_OFS_DBGIRQ) begin
				next_st.irq_req = req_wdata[`TDSC_IRQ_REQ_BIT];
			end else begin
				next_st.clk_off   = req_wdata[`TDSC_DIV_OFF_BIT];
				next_st.div_ratio = req_wdata[15:0];
			end
		end
		// security word: OTP load, else a permitted write
		if (otp_word_valid) begin
			next_st.sec = otp_word & `TDSC_SEC_MASK;
		end else if (wr && req_addr == `TDSC_OFS_SECURITY) begin
			if (st.sec[`TDSC_SEC_WLOCK_BIT]) begin
				next_st.rsp_refused = 1'b1;
			end else begin
				next_st.sec = req_wdata & `TDSC_SEC_MASK;
			end
		end
		// sector locks follow the word held
		next_st.otp_lock = next_st.sec[`TDSC_SEC_SECT_HI:`TDSC_SEC_SECT_LO]
			| {4{next_st.sec[`TDSC_SEC_ALLOTP]}};
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign rsp_valid          = st.rsp_valid;
	assign rsp_refused        = st.rsp_refused;
	assign rsp_rdata          = st.rsp_rdata;
	assign debug_irq          = st.irq_req;
	assign tile_clk_off       = st.clk_off;
	assign tile_div_ratio     = st.div_ratio;
	assign tile_div_active    = st.div_active;
	assign global_debug_block = st.sec[`TDSC_SEC_GDBG_BIT];
	assign otp_sector_lock    = st.otp_lock;
	assign boot_from_otp      = st.sec[`TDSC_SEC_BOOT_BIT];
	assign jtag_pll_boot_deny = st.sec[`TDSC_SEC_JPLL_BIT];
	assign jtag_tap_deny      = st.sec[`TDSC_SEC_JTAP_BIT];

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_dbg_write;
		req_valid && req_write && req_addr inside {`TDSC_OFS_PERM, `TDSC_OFS_DBGIRQ, `TDSC_OFS_CLKDIV};
	endsequence
	sequence s_sec_write;
		req_valid && req_write && !otp_word_valid && req_addr == `TDSC_OFS_SECURITY;
	endsequence
	// security word load from otp
	sequence s_otp_load;
		otp_word_valid;
	endsequence

	a_all_lock_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_dbg_write and (st.perm[31] == 1'b1) |=> rsp_refused && $stable(tile_div_ratio))
		else $error("debug write taken while fully locked");
	a_sys_lock_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_dbg_write and (st.perm[0] && !st.perm[31] && req_src == tdsc_pkg::SRC_SYSTEM_SWITCH)
		|=> rsp_refused)
		else $error("system switch write taken while locked");
	a_sys_lock_other: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_dbg_write and (!st.perm[31] && req_src == tdsc_pkg::SRC_JTAG) |=> !rsp_refused)
		else $error("jtag write refused without full lock");
	a_irq_raise: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && req_write && req_addr == 8'h05 && req_wdata[0] && dbg_wr_ok |=> debug_irq)
		else $error("debug interrupt not raised");
	a_mode_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		##1 req_valid && !req_write && req_addr == 8'h05 |=> rsp_rdata[1] == $past(cpu_debug_mode, 2))
		else $error("debug mode bit wrong");
	a_clk_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && req_write && req_addr == 8'h06 && dbg_wr_ok
		|=> tile_clk_off == $past(req_wdata[31]) && tile_div_ratio == $past(req_wdata[15:0]))
		else $error("divider write not applied");
	a_div_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> tile_div_active == $past(tile_div_enable))
		else $error("divider active does not follow enable");
	a_sec_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_otp_load |=> st.sec == ($past(otp_word) & 32'h8000_5fb1))
		else $error("security copy wrong");
	a_sec_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && !req_write && req_addr == 8'h07 |=> rsp_rdata == $past(st.sec))
		else $error("security read wrong");
	a_gdbg_block: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_otp_load |=> global_debug_block == $past(otp_word[14]))
		else $error("global debug block wrong");
	a_boot_otp: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_otp_load |=> boot_from_otp == $past(otp_word[5]))
		else $error("boot override wrong");
	a_jtag_pll: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_otp_load |=> jtag_pll_boot_deny == $past(otp_word[4]))
		else $error("jtag pll deny wrong");
	a_jtag_tap: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_otp_load |=> jtag_tap_deny == $past(otp_word[0]))
		else $error("jtag tap deny wrong");
	a_sect_single: assert property (@(posedge core_clk) disable iff (!rst_n)
		otp_word_valid && !otp_word[12] |=> otp_sector_lock == $past(otp_word[11:8]))
		else $error("single sector lock wrong");
	a_sec_wlock: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_sec_write and st.sec[31] |=> rsp_refused && $stable(st.sec))
		else $error("locked security word changed");
	a_sect_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
		st.sec[12] |-> otp_sector_lock == 4'hf)
		else $error("all-sector lock not applied");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && !req_write && req_addr == 8'h04 |=> rsp_rdata[30:1] == 30'h0000_0000)
		else $error("reserved bits not zero");
	a_irq_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && req_write && req_addr == 8'h05 && !req_wdata[0] && dbg_wr_ok |=> !debug_irq)
		else $error("debug interrupt not cleared");
	a_ratio_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(req_valid && req_write && req_addr == 8'h06) |=> $stable(tile_div_ratio))
		else $error("divider ratio changed without write");
	a_irq_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && !req_write && req_addr == 8'h05 |=> rsp_rdata[31:2] == 30'h0000_0000)
		else $error("interrupt reserved bits not zero");
	a_div_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && !req_write && req_addr == 8'h06 |=> rsp_rdata[30:16] == 15'h0000)
		else $error("divider reserved bits not zero");
	a_sec_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_valid && !req_write && req_addr == 8'h07 |=> (rsp_rdata & 32'h7fff_a04e) == 32'h0000_0000)
		else $error("security reserved bits not zero");
endmodule // tdsc_regs
